// file: vmc_ctrl.v
// Voltage memory controller with Avalon-MM register slave.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "vmc_defs.vh"
module vmc_ctrl #(
    parameter DW       = 16,
    parameter UNIT_CYC = `VMC_HOLD_UNIT_CYC
) (
    // Clock and reset.
    input  wire          clock,
    input  wire          sys_rst,
    // Avalon-MM slave.
    input  wire [3:0]    address,
    input  wire          read,
    input  wire          write,
    input  wire [31:0]   writedata,
    output reg  [31:0]   readdata,
    output wire          waitrequest,
    output wire          irq,
    // Measurement front end.
    input  wire          meas_valid,
    input  wire [DW-1:0] phase_a_current_rms,
    input  wire [DW-1:0] phase_b_current_rms,
    input  wire [DW-1:0] phase_c_current_rms,
    input  wire [DW-1:0] voltage_ch1_rms,
    input  wire [DW-1:0] voltage_ch2_rms,
    input  wire [DW-1:0] voltage_ch3_rms,
    input  wire [DW-1:0] voltage_ch4_rms,
    input  wire [DW-1:0] voltage_angle,
    // Blocking pin.
    input  wire          hold_block_pin,
    // Outputs to directional and distance functions, and frequency choice for sampling.
    output reg           mem_on,
    output reg  [DW-1:0] ref_amplitude,
    output reg  [DW-1:0] ref_angle,
    output reg           nondir_fallback,
    output reg  [1:0]    freq_source,
    output reg           nominal_60hz,
    // Event strobes.
    output reg  [5:0]    event_on,
    output reg  [5:0]    event_off
);
    localparam ST_IDLE    = 2'h0;
    localparam ST_ACTIVE  = 2'h1;
    localparam ST_EXPIRED = 2'h2;

    reg  [31:0]   ctrl_reg;
    reg  [DW-1:0] vthr_reg;
    reg  [DW-1:0] ithr_reg;
    reg  [15:0]   hold_reg;
    reg  [5:0]    irq_stat_reg;
    reg  [5:0]    irq_mask_reg;
    reg           ack_reg;
    reg  [1:0]    st_reg;
    reg  [1:0]    st_next;
    reg           vlow_reg;
    reg           chigh_reg;
    reg           blocked_reg;
    reg           blk_s1_reg;
    reg           blk_s2_reg;
    reg  [31:0]   tick_reg;
    reg  [15:0]   units_reg;
    reg  [5:0]    prev_reg;
    reg  [31:0]   rd_next;

    wire          en       = ctrl_reg[`VMC_CTRL_EN];
    wire [1:0]    mode     = ctrl_reg[`VMC_CTRL_MODE_LO +: 2];
    wire [1:0]    evsel    = ctrl_reg[`VMC_CTRL_EVSEL_LO +: 2];
    wire          two_line = (mode == `VMC_MODE_TWO_LINE);
    wire          v_low_now;
    wire          i_high_now;
    wire          expired  = (units_reg >= hold_reg);
    wire          ftrack;
    wire [5:0]    status;
    wire [5:0]    rise;
    wire [5:0]    fall;
    wire [5:0]    ev_on_sel;
    wire [5:0]    ev_off_sel;

    // Residual mode expects the front end to deliver computed phase-to-neutral values on 1..3.
    assign v_low_now = (voltage_ch1_rms < vthr_reg) && (voltage_ch2_rms < vthr_reg) &&
                       (two_line || (voltage_ch3_rms < vthr_reg)); // [RULE_02] [RULE_03]
    assign i_high_now = (phase_a_current_rms > ithr_reg) || (phase_b_current_rms > ithr_reg) ||
                        (phase_c_current_rms > ithr_reg);
    assign ftrack = en && ctrl_reg[`VMC_CTRL_FORCECT] && vlow_reg; // [RULE_08]
    assign status = {blocked_reg, mem_on, ftrack, chigh_reg, vlow_reg, en};
    assign rise   = status & ~prev_reg;
    assign fall   = ~status & prev_reg;
    assign ev_on_sel  = (evsel != `VMC_EVSEL_OFF) ? rise : 6'h00; // [RULE_10]
    assign ev_off_sel = (evsel != `VMC_EVSEL_ON) ? fall : 6'h00; // [RULE_10]
    assign waitrequest = (read || write) && !ack_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Two flip-flops guard the blocking pin against metastability.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            blk_s1_reg <= 1'b0;
            blk_s2_reg <= 1'b0;
        end else begin
            blk_s1_reg <= hold_block_pin;
            blk_s2_reg <= blk_s1_reg;
        end
    end

    // Conditions are evaluated once per program cycle, marked by each fresh measurement set.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vlow_reg    <= 1'b0;
            chigh_reg   <= 1'b0;
            blocked_reg <= 1'b0;
        end else if (!en) begin
            vlow_reg    <= 1'b0; // [RULE_14]
            chigh_reg   <= 1'b0;
            blocked_reg <= 1'b0;
        end else if (meas_valid) begin // [RULE_01]
            vlow_reg    <= v_low_now;
            chigh_reg   <= i_high_now;
            blocked_reg <= blk_s2_reg; // [RULE_12]
        end
    end

    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (meas_valid && v_low_now && !blk_s2_reg &&
                    (!ctrl_reg[`VMC_CTRL_ICOND] || i_high_now)) begin // [RULE_03] [RULE_04]
                    st_next = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (meas_valid && (blk_s2_reg || !v_low_now)) begin // [RULE_12] [RULE_13]
                    st_next = ST_IDLE;
                end else if (expired) begin
                    st_next = ST_EXPIRED; // [RULE_05]
                end
            end
            ST_EXPIRED: begin
                if (meas_valid && !v_low_now) begin
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (!en) begin
            st_next = ST_IDLE; // [RULE_14]
        end
    end

    // The hold timer counts 10 ms units; it is cleared whenever memory is not in use.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg    <= ST_IDLE;
            tick_reg  <= 32'h0000_0000;
            units_reg <= 16'h0000;
        end else begin
            st_reg <= st_next;
            if (st_next != ST_ACTIVE) begin
                tick_reg  <= 32'h0000_0000; // [RULE_14]
                units_reg <= 16'h0000;
            end else if (tick_reg == UNIT_CYC - 1) begin
                tick_reg  <= 32'h0000_0000;
                units_reg <= units_reg + 16'h0001; // [RULE_05]
            end else begin
                tick_reg  <= tick_reg + 32'h0000_0001;
            end
        end
    end

    // Memory outputs follow the state, frequency outputs the control bits and voltage-low; the angle is frozen while active or expired, and refreshes only in idle.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mem_on          <= 1'b0;
            ref_amplitude   <= {DW{1'b0}};
            ref_angle       <= {DW{1'b0}};
            nondir_fallback <= 1'b0;
            freq_source     <= `VMC_FREQ_VOLT;
            nominal_60hz    <= 1'b0;
        end else begin
            mem_on          <= (st_next == ST_ACTIVE); // [RULE_11]
            ref_amplitude   <= (st_next == ST_ACTIVE) ? vthr_reg : {DW{1'b0}}; // [RULE_11]
            nondir_fallback <= (st_next == ST_EXPIRED); // [RULE_06]
            if (st_reg == ST_IDLE && st_next == ST_IDLE && meas_valid) begin
                ref_angle <= voltage_angle; // [RULE_13]
            end
            if (ftrack) begin
                freq_source <= `VMC_FREQ_CT3; // [RULE_08]
            end else if (ctrl_reg[`VMC_CTRL_FIXED]) begin
                freq_source <= `VMC_FREQ_FIXED; // [RULE_07]
            end else begin
                freq_source <= `VMC_FREQ_VOLT;
            end
            nominal_60hz <= ctrl_reg[`VMC_CTRL_F60]; // [RULE_07]
        end
    end

    // Status edges become event strobes and sticky interrupt bits.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_reg  <= 6'h00;
            event_on  <= 6'h00;
            event_off <= 6'h00;
        end else begin
            prev_reg  <= status;
            event_on  <= ev_on_sel; // [RULE_09]
            event_off <= ev_off_sel; // [RULE_09]
        end
    end

    always @* begin
        case (address)
            `VMC_ADR_CTRL:     rd_next = ctrl_reg;
            `VMC_ADR_VTHR:     rd_next = {{(32-DW){1'b0}}, vthr_reg};
            `VMC_ADR_ITHR:     rd_next = {{(32-DW){1'b0}}, ithr_reg};
            `VMC_ADR_HOLD:     rd_next = {16'h0000, hold_reg};
            `VMC_ADR_STATUS:   rd_next = {25'h0, nondir_fallback, status};
            `VMC_ADR_IRQ_STAT: rd_next = {26'h0, irq_stat_reg};
            `VMC_ADR_IRQ_MASK: rd_next = {26'h0, irq_mask_reg};
            `VMC_ADR_ANGLE:    rd_next = {{(32-DW){1'b0}}, ref_angle};
            default:           rd_next = 32'h0000_0000;
        endcase
    end

    // Every access takes two cycles: waitrequest is low in the second one.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg      <= 1'b0;
            readdata     <= 32'h0000_0000;
            ctrl_reg     <= `VMC_CTRL_RST;
            vthr_reg     <= `VMC_VTHR_RST;
            ithr_reg     <= `VMC_ITHR_RST;
            hold_reg     <= `VMC_HOLD_RST;
            irq_mask_reg <= 6'h00;
            irq_stat_reg <= 6'h00;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
            if (read && !ack_reg) begin
                readdata <= rd_next;
            end
            if (write && ack_reg) begin
                case (address)
                    `VMC_ADR_CTRL:     ctrl_reg <= writedata;
                    `VMC_ADR_VTHR:     vthr_reg <= writedata[DW-1:0];
                    `VMC_ADR_ITHR:     ithr_reg <= writedata[DW-1:0];
                    `VMC_ADR_HOLD:     hold_reg <= writedata[15:0];
                    `VMC_ADR_IRQ_MASK: irq_mask_reg <= writedata[5:0];
                    default:           ;
                endcase
            end
            // Only the bits the read reported are cleared, so an event in either cycle survives.
            if (read && ack_reg && address == `VMC_ADR_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~readdata[5:0]) | ev_on_sel | ev_off_sel;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev_on_sel | ev_off_sel;
            end
        end
    end
endmodule // vmc_ctrl

// file: vmc_defs.vh
// Constants for the voltage memory controller.
// Summary of operation
// RULE_01: The measurement front end delivers fresh RMS currents and voltages every 5 ms period.
// RULE_02: Monitored voltages are channels 1 to 3 in three-phase modes and channels 1 and 2 in two-line mode.
// RULE_03: When enabled, voltage-low is raised only while every monitored voltage is below the threshold.
// RULE_04: With the current condition selected, at least one phase current must exceed the pick-up.
// RULE_05: Each memory activation is limited by a definite-time timer of 0.02 to 50.00 s.
// RULE_06: After the timer expires the directional functions are told to fall back to non-directional.
// RULE_07: With fixed tracking, sampling uses the nominal 50 Hz or 60 Hz, frequency protection excepted.
// RULE_08: Forced current tracking with voltages gone takes frequency from reference 3, phase C current.
// RULE_09: ON and OFF events are raised for enable, voltage low, current high, tracking, memory, block.
// RULE_10: A selection stores only ON events, only OFF events, or both.
// RULE_11: While memory is active the reference has threshold amplitude and the held angle.
// RULE_12: The block input is sampled at each program cycle start and prevents or ends memory use.
// RULE_13: The angle refreshes while memory is idle, freezes at activation, and memory ends on recovery.
// RULE_14: Reset or disabling clears all status outputs and the active-time timer.
`ifndef VMC_DEFS_VH
`define VMC_DEFS_VH
`define VMC_ADR_CTRL      4'h0
`define VMC_ADR_VTHR      4'h1
`define VMC_ADR_ITHR      4'h2
`define VMC_ADR_HOLD      4'h3
`define VMC_ADR_STATUS    4'h4
`define VMC_ADR_IRQ_STAT  4'h5
`define VMC_ADR_IRQ_MASK  4'h6
`define VMC_ADR_ANGLE     4'h7
`define VMC_CTRL_EN       0
`define VMC_CTRL_ICOND    1
`define VMC_CTRL_FORCECT  2
`define VMC_CTRL_FIXED    3
`define VMC_CTRL_F60      4
`define VMC_CTRL_MODE_LO  5
`define VMC_CTRL_EVSEL_LO 8
`define VMC_MODE_THREE_PN 2'h0
`define VMC_MODE_THREE_LN 2'h1
`define VMC_MODE_TWO_LINE 2'h2
`define VMC_MODE_TWO_RES  2'h3
`define VMC_EVSEL_ON      2'h1
`define VMC_EVSEL_OFF     2'h2
`define VMC_CTRL_RST      32'h0000_0300
`define VMC_VTHR_RST      16'h0014
`define VMC_ITHR_RST      16'h0064
`define VMC_HOLD_RST      16'h0032
`define VMC_FREQ_VOLT     2'h0
`define VMC_FREQ_FIXED    2'h1
`define VMC_FREQ_CT3      2'h2
`define VMC_CLK_MHZ       100
`define VMC_HOLD_UNIT_MS  10
`define VMC_HOLD_UNIT_CYC (`VMC_HOLD_UNIT_MS * 1000 * `VMC_CLK_MHZ)
`endif

// file: vmc_props.sv
// Port checker for the voltage memory controller.
`timescale 1ns/10ps
module vmc_props #(parameter DW = 16) (
    // Clock and reset.
    input wire          clock,
    input wire          sys_rst,
    // Bus handshake.
    input wire          read,
    input wire          waitrequest,
    // Measurement and outputs.
    input wire          meas_valid,
    input wire          mem_on,
    input wire [DW-1:0] ref_amplitude,
    input wire [DW-1:0] ref_angle,
    input wire          nondir_fallback,
    input wire [1:0]    freq_source,
    input wire [5:0]    event_on,
    input wire [5:0]    event_off
);
    default clocking cb_clk @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_act; $rose(mem_on) |-> $past(meas_valid); endproperty
    a_act: assert property (p_act) else $error("memory started off a set");
    property p_amp; !mem_on |-> ref_amplitude == 0; endproperty
    a_amp: assert property (p_amp) else $error("reference while idle");
    property p_ang; mem_on && $past(mem_on) |-> $stable(ref_angle); endproperty
    a_ang: assert property (p_ang) else $error("held angle moved");
    property p_fb; nondir_fallback |-> !mem_on; endproperty
    a_fb: assert property (p_fb) else $error("fallback with memory on");
    property p_fs; freq_source != 2'h3; endproperty
    a_fs: assert property (p_fs) else $error("bad frequency source");
    property p_on4; event_on[4] |-> $past(mem_on) && !$past(mem_on, 2); endproperty
    a_on4: assert property (p_on4) else $error("memory on event misplaced");
    property p_off4; event_off[4] |-> !$past(mem_on) && $past(mem_on, 2); endproperty
    a_off4: assert property (p_off4) else $error("memory off event misplaced");
    property p_excl; (event_on & event_off) == 6'h00; endproperty
    a_excl: assert property (p_excl) else $error("on and off together");
    property p_ack; $rose(read) |-> waitrequest ##1 !waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("read not answered in two cycles");
endmodule // vmc_props
bind vmc_ctrl vmc_props #(.DW(DW)) u_props (.clock, .sys_rst, .read, .waitrequest, .meas_valid,
    .mem_on, .ref_amplitude, .ref_angle, .nondir_fallback, .freq_source, .event_on, .event_off);

// file: vmc_front.sv
// Measurement front end model delivering periodic RMS sets.
`timescale 1ns/10ps
module vmc_front #(parameter PER = 20) (
    // Clock and reset.
    input  wire        clock,
    input  wire        sys_rst,
    // Levels chosen by the bench.
    input  wire [15:0] v12,
    input  wire [15:0] v3,
    input  wire [15:0] cur,
    // Fresh set towards the controller.
    output reg         meas_valid,
    output reg  [15:0] cur_rms,
    output reg  [15:0] v12_rms,
    output reg  [15:0] v3_rms,
    output reg  [15:0] ang
);
    reg [7:0] cnt_reg;
    // The angle steps every set so a held angle is told apart from a refreshed one.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg    <= 8'h00;
            meas_valid <= 1'b0;
            ang        <= 16'h0000;
        end else begin
            cnt_reg    <= (cnt_reg == PER - 1) ? 8'h00 : cnt_reg + 8'h01;
            meas_valid <= (cnt_reg == PER - 1);
            if (cnt_reg == PER - 1) begin
                cur_rms <= cur;
                v12_rms <= v12;
                v3_rms  <= v3;
                ang     <= ang + 16'h0011;
            end
        end
    end
endmodule // vmc_front

// file: tb_top.sv
// Self-checking bench for the voltage memory controller.
`timescale 1ns/10ps
`include "vmc_defs.vh"
module tb_top;
    logic        clock, sys_rst, read, write, hold_block_pin, waitrequest, irq, meas_valid;
    logic        mem_on, nondir_fallback, nominal_60hz;
    logic [3:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [15:0] v12, v3, cur, cur_rms, v12_rms, v3_rms, ang, ref_amplitude, ref_angle, held;
    logic [1:0]  freq_source;
    logic [5:0]  event_on, event_off;
    int          fails, checks, cyc, n_on, n_off;
    vmc_ctrl #(.UNIT_CYC(10)) DUT (.*, .phase_a_current_rms(cur_rms),
        .phase_b_current_rms(cur_rms), .phase_c_current_rms(cur_rms), .voltage_ch1_rms(v12_rms),
        .voltage_ch2_rms(v12_rms), .voltage_ch3_rms(v3_rms), .voltage_ch4_rms(v3_rms),
        .voltage_angle(ang));
    vmc_front #(.PER(20)) u_fe (.clock, .sys_rst, .v12, .v3, .cur, .meas_valid, .cur_rms,
        .v12_rms, .v3_rms, .ang);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // The ceiling is some forty times the length of the whole sequence.
    always @(posedge clock) begin
        cyc++;
        if (event_on !== 6'h00) n_on++;
        if (event_off !== 6'h00) n_off++;
        if (cyc == 20000) begin
            fails++;
            summarize;
        end
    end
    task automatic summarize;
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic ok;
        @(posedge clock);
        read      <= !w;
        write     <= w;
        address   <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            ok = (waitrequest === 1'b0);
            q  = readdata;
        end while (!ok);
        read  <= 1'b0;
        write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic mv;
        do begin
            @(posedge clock);
        end while (meas_valid !== 1'b1);
        #1;
    endtask
    // Levels change on a sampled set, so the front end takes them on the next one.
    task automatic set(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        do begin
            @(posedge clock);
        end while (meas_valid !== 1'b1);
        v12 <= a;
        v3  <= b;
        cur <= c;
        mv;
    endtask
    initial begin
        {sys_rst, read, write, hold_block_pin, address, writedata} = {4'h8, 36'h0};
        {v12, v3, cur} = {16'h0064, 16'h0064, 16'h0000};
        {fails, checks, cyc, n_on, n_off} = '0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(`VMC_ADR_CTRL, 32'h300);
        rd(`VMC_ADR_VTHR, 32'h14);
        rd(`VMC_ADR_ITHR, 32'h64);
        rd(`VMC_ADR_HOLD, 32'h32);
        rd(4'h8, 32'h0);
        acc(1'b1, `VMC_ADR_HOLD, 32'h3);
        acc(1'b1, `VMC_ADR_IRQ_MASK, 32'h10);
        acc(1'b1, `VMC_ADR_CTRL, 32'h301);
        set(16'h0064, 16'h0064, 16'h0000);
        cb(mem_on, 1'b0);
        set(16'h000a, 16'h000a, 16'h0000);
        cb(mem_on, 1'b1);
        chk({16'h0, ref_amplitude}, 32'h14);
        repeat (27) @(posedge clock);
        #1;
        cb(mem_on, 1'b1);
        cb(irq, 1'b1);
        repeat (6) @(posedge clock);
        #1;
        cb(mem_on, 1'b0);
        cb(nondir_fallback, 1'b1);
        chk(n_off, 32'h1);
        rd(`VMC_ADR_STATUS, 32'h43);
        rd(`VMC_ADR_IRQ_STAT, 32'h13);
        cb(irq, 1'b0);
        set(16'h0064, 16'h0064, 16'h0000);
        cb(nondir_fallback, 1'b0);
        // A longer hold lets the block input end the memory before the timer does.
        acc(1'b1, `VMC_ADR_HOLD, 32'h8);
        acc(1'b1, `VMC_ADR_CTRL, 32'h303);
        set(16'h000a, 16'h000a, 16'h0000);
        cb(mem_on, 1'b0);
        held = ref_angle;
        set(16'h000a, 16'h000a, 16'h00c8);
        cb(mem_on, 1'b1);
        cb(ref_angle !== held, 1'b1);
        held = ref_angle;
        mv;
        chk({16'h0, ref_angle}, {16'h0, held});
        @(posedge clock);
        hold_block_pin <= 1'b1;
        mv;
        cb(mem_on, 1'b0);
        rd(`VMC_ADR_STATUS, 32'h27);
        @(posedge clock);
        hold_block_pin <= 1'b0;
        acc(1'b1, `VMC_ADR_CTRL, 32'h300);
        rd(`VMC_ADR_STATUS, 32'h0);
        n_on = 0;
        acc(1'b1, `VMC_ADR_CTRL, 32'h201);
        mv;
        cb(mem_on, 1'b1);
        acc(1'b1, `VMC_ADR_CTRL, 32'h305);
        chk(n_on, 32'h0);
        mv;
        chk({30'h0, freq_source}, 32'h2);
        acc(1'b1, `VMC_ADR_CTRL, 32'h319);
        mv;
        chk({30'h0, freq_source}, 32'h1);
        cb(nominal_60hz, 1'b1);
        n_off = 0;
        // Only two-line mode ignores channel 3, so only there the memory starts.
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, `VMC_ADR_CTRL, 32'h101 | (32'(m) << 5));
            set(16'h000a, 16'h0064, 16'h0000);
            cb(mem_on, m == 2);
        end
        chk(n_off, 32'h0);
        summarize;
    end
endmodule // tb_top
